// ===== include/pfr_pkg.sv
/*
 Package for the power fault restart controller: setting encodings,
 timing constants and state encoding.
 Assumes a single 250 MHz controller clock and a 1 ms tick divider.
*/
package pfr_pkg;
	localparam logic [1:0] MODE_TRIP = 2'h0;
	localparam logic [1:0] MODE_ZERO = 2'h1;
	localparam logic [1:0] MODE_MATCH = 2'h2;
	localparam logic [1:0] MODE_MATCH_STOP = 2'h3;
	localparam logic [1:0] ALM_OFF = 2'h0;
	localparam logic [1:0] ALM_ON = 2'h1;
	localparam logic [1:0] ALM_OFF_STOPPING = 2'h2;
	localparam logic [1:0] CNT_LIMITED = 2'h0;
	localparam logic [1:0] CNT_UNLIMITED = 2'h1;
	localparam int PWR_RETRY_MAX = 16;
	localparam int OCV_RETRY_MAX = 3;
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	// Times given to the block in units of 1 ms ticks
	localparam int TIME_W = 17;
	localparam logic [15:0] FREQ_ZERO = 16'h0000;
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_SAG = 5'h02,
		ST_WAIT = 5'h04,
		ST_DECEL = 5'h08,
		ST_TRIP = 5'h10
	} pfr_state_t;
endpackage

// ===== design/pfr_sync.sv
/*
 Three-flop synchroniser with agreement filter for pin inputs.
 Assumes the input is asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pfr_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_dout;
	always_comb begin
		next_dout = dout;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				next_dout[i] = s2[i];
			end
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule
`default_nettype wire

// ===== design/pfr_ctrl.sv
/*
 Power fault restart controller: decides trip or retry after power loss,
 under-voltage, over-current and over-voltage; counts retries, times the
 sag and the retry wait, and picks the restart frequency.
 Assumes supply and fault inputs come from pins; settings are static
 ports from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pfr_ctrl
	import pfr_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic power_loss_in,
	input wire logic undervolt_in,
	input wire logic overcurrent_in,
	input wire logic overvolt_in,
	input wire logic stop_reset,
	input wire logic [1:0] restart_mode_select,
	input wire logic [TIME_W-1:0] undervoltage_ride_through_time,
	input wire logic [TIME_W-1:0] retry_wait_time,
	input wire logic [1:0] power_fault_alarm_enable,
	input wire logic [1:0] restart_count_mode,
	input wire logic [15:0] restart_freq_threshold,
	input wire logic [15:0] motor_freq,
	input wire logic motor_stopped,
	input wire logic stopping,
	output logic drive_enable,
	output logic restart_start,
	output logic [15:0] restart_freq,
	output logic decel_request,
	output logic tripped,
	output logic alarm,
	output logic power_loss_flag,
	output logic low_supply_flag
);
	logic [3:0] pins;
	logic ploss, uv, oc, ov;
	pfr_sync #(.W(4)) u_sync (
		.mclk(mclk),
		.resetn(resetn),
		.din({power_loss_in, undervolt_in, overcurrent_in, overvolt_in}),
		.dout(pins)
	);
	assign {ploss, uv, oc, ov} = pins;

	// Millisecond tick keeps timers narrow at the cost of 1 ms resolution
	logic [31:0] div_cnt, next_div_cnt;
	logic tick;
	always_comb begin
		tick = (div_cnt == 32'(TICK_DIV - 1));
		next_div_cnt = tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 32'h0000_0000;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	pfr_state_t state, next_state;
	logic [TIME_W-1:0] timer, next_timer;
	logic [4:0] pwr_cnt, next_pwr_cnt;
	logic [2:0] ocv_cnt, next_ocv_cnt;
	logic pwr_fault, ocv_fault;
	logic next_tripped, next_alarm, next_start, next_decel, next_drive;
	logic [15:0] next_freq;

	always_comb begin
		pwr_fault = ploss | uv;
		ocv_fault = oc | ov;
		next_state = state;
		next_timer = timer;
		next_pwr_cnt = pwr_cnt;
		next_ocv_cnt = ocv_cnt;
		next_tripped = tripped;
		next_alarm = alarm;
		next_start = 1'b0;
		next_decel = decel_request;
		next_drive = drive_enable;
		next_freq = restart_freq;
		case (state)
			ST_RUN: begin
				if (ocv_fault) begin
					next_drive = 1'b0;
					next_timer = '0;
					if (restart_mode_select == MODE_TRIP ||
						ocv_cnt == 3'(OCV_RETRY_MAX)) begin
						next_state = ST_TRIP;
						next_tripped = 1'b1;
						next_alarm = 1'b1;
					end else begin
						next_ocv_cnt = ocv_cnt + 3'h1;
						next_state = ST_WAIT;
					end
				end else if (pwr_fault) begin
					next_drive = 1'b0;
					next_timer = '0;
					if (restart_mode_select == MODE_TRIP) begin
						next_state = ST_TRIP;
						next_tripped = 1'b1;
						next_alarm = (power_fault_alarm_enable == ALM_ON) ||
							(power_fault_alarm_enable == ALM_OFF_STOPPING && !stopping && !motor_stopped);
					end else begin
						next_state = ST_SAG;
					end
				end
			end
			ST_SAG: begin
				if (tick) begin
					next_timer = timer + TIME_W'(1);
				end
				if (timer > undervoltage_ride_through_time) begin
					next_state = ST_TRIP;
					next_tripped = 1'b1;
					next_alarm = (power_fault_alarm_enable == ALM_ON) ||
						(power_fault_alarm_enable == ALM_OFF_STOPPING && !stopping && !motor_stopped);
				end else if (!pwr_fault) begin
					next_timer = '0;
					if (restart_count_mode == CNT_LIMITED &&
						pwr_cnt == 5'(PWR_RETRY_MAX)) begin
						next_state = ST_TRIP;
						next_tripped = 1'b1;
						next_alarm = 1'b1;
					end else begin
						if (restart_count_mode == CNT_LIMITED) begin
							next_pwr_cnt = pwr_cnt + 5'h01;
						end
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (pwr_fault || ocv_fault) begin
					next_timer = '0;
				end else if (tick) begin
					next_timer = timer + TIME_W'(1);
				end
				if (!pwr_fault && !ocv_fault && timer >= retry_wait_time) begin
					next_timer = '0;
					next_start = 1'b1;
					next_drive = 1'b1;
					if (restart_mode_select == MODE_ZERO ||
						motor_freq < restart_freq_threshold) begin
						next_freq = FREQ_ZERO;
					end else begin
						next_freq = motor_freq;
					end
					if (restart_mode_select == MODE_MATCH_STOP) begin
						next_state = ST_DECEL;
						next_decel = 1'b1;
					end else begin
						next_state = ST_RUN;
					end
				end
			end
			ST_DECEL: begin
				if (motor_stopped) begin
					next_state = ST_TRIP;
					next_decel = 1'b0;
					next_drive = 1'b0;
					next_tripped = 1'b1;
					next_alarm = 1'b1;
				end
			end
			ST_TRIP: begin
				next_drive = 1'b0;
				if (stop_reset) begin
					next_state = ST_RUN;
					next_tripped = 1'b0;
					next_alarm = 1'b0;
					next_pwr_cnt = '0;
					next_ocv_cnt = '0;
					next_timer = '0;
				end
			end
			default: begin
				next_state = ST_TRIP;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_RUN;
			timer <= '0;
			pwr_cnt <= 5'h00;
			ocv_cnt <= 3'h0;
			tripped <= 1'b0;
			alarm <= 1'b0;
			restart_start <= 1'b0;
			decel_request <= 1'b0;
			drive_enable <= 1'b1;
			restart_freq <= FREQ_ZERO;
			power_loss_flag <= 1'b0;
			low_supply_flag <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			pwr_cnt <= next_pwr_cnt;
			ocv_cnt <= next_ocv_cnt;
			tripped <= next_tripped;
			alarm <= next_alarm;
			restart_start <= next_start;
			decel_request <= next_decel;
			drive_enable <= next_drive;
			restart_freq <= next_freq;
			power_loss_flag <= ploss;
			low_supply_flag <= uv;
		end
	end

	a_pwr_limit: assert property (@(posedge mclk) disable iff (!resetn)
		pwr_cnt <= 5'(PWR_RETRY_MAX)) else $error("power retry count above limit");
	a_ocv_limit: assert property (@(posedge mclk) disable iff (!resetn)
		ocv_cnt <= 3'(OCV_RETRY_MAX)) else $error("fault retry count above limit");
	a_mode_trip: assert property (@(posedge mclk) disable iff (!resetn)
		restart_start |-> restart_mode_select != MODE_TRIP) else $error("restart in trip mode");
	a_zero_freq: assert property (@(posedge mclk) disable iff (!resetn)
		restart_start && $past(restart_mode_select) == MODE_ZERO |-> restart_freq == FREQ_ZERO)
		else $error("mode 01 restart not at 0 Hz");
	sequence s_decel_done;
		state == ST_DECEL && motor_stopped;
	endsequence
	a_decel_trip: assert property (@(posedge mclk) disable iff (!resetn)
		s_decel_done |=> tripped && alarm && !decel_request) else $error("no trip after stop");
	a_wait_time: assert property (@(posedge mclk) disable iff (!resetn)
		restart_start |-> $past(timer) >= $past(retry_wait_time)) else $error("restart before wait");
	a_loss_flag: assert property (@(posedge mclk) disable iff (!resetn)
		power_loss_flag == $past(ploss)) else $error("power loss flag wrong");
	a_uv_flag: assert property (@(posedge mclk) disable iff (!resetn)
		low_supply_flag == $past(uv)) else $error("low supply flag wrong");
	a_clear_cnt: assert property (@(posedge mclk) disable iff (!resetn)
		state == ST_TRIP && stop_reset |=> pwr_cnt == 5'h00 && ocv_cnt == 3'h0 && !tripped)
		else $error("counters not cleared");
endmodule
`default_nettype wire

// ===== verification/pfr_drive_model.sv
/*
 Drive stage stand-in: reports motor speed set by the bench.
 Assumes the bench owns speed; decel follows the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module pfr_drive_model (
	input wire logic [15:0] speed,
	input wire logic decel_request,
	output logic [15:0] motor_freq,
	output logic motor_stopped,
	output logic stopping
);
	assign motor_freq = speed;
	assign motor_stopped = (speed == 16'h0000);
	// Ramp only while a decel is asked and not yet at rest
	assign stopping = decel_request & ~motor_stopped;
endmodule
`default_nettype wire

// ===== verification/power_fault_restart_control_tb_top.sv
/*
 Sequence bench for the restart controller.
 Assumes a 4-cycle tick so waits stay short.
*/
`timescale 1ns/1ps
`default_nettype none
module power_fault_restart_control_tb_top;
	import pfr_pkg::*;
	logic mclk = 0, resetn = 0, stop_reset = 0;
	logic [3:0] flt = 4'h0;
	logic [1:0] mode = 2'h1, alm = 2'h1, cnt = 2'h0;
	logic [15:0] speed = 16'h0000;
	logic [15:0] motor_freq, restart_freq;
	logic motor_stopped, stopping, drive_enable, restart_start, decel_request, tripped, alarm, plf, lsf;
	int bad_count = 0, cmp_count = 0, i;
	initial forever #2 mclk = ~mclk;
	pfr_ctrl #(.TICK_DIV(4)) pfr_ctrl_inst (.mclk(mclk), .resetn(resetn), .power_loss_in(flt[0]),
		.undervolt_in(flt[1]), .overcurrent_in(flt[2]), .overvolt_in(flt[3]), .stop_reset(stop_reset),
		.restart_mode_select(mode), .undervoltage_ride_through_time(17'h0_0003), .retry_wait_time(17'h0_0002),
		.power_fault_alarm_enable(alm), .restart_count_mode(cnt), .restart_freq_threshold(16'h0064),
		.motor_freq(motor_freq), .motor_stopped(motor_stopped), .stopping(stopping),
		.drive_enable(drive_enable), .restart_start(restart_start), .restart_freq(restart_freq),
		.decel_request(decel_request), .tripped(tripped), .alarm(alarm), .power_loss_flag(plf),
		.low_supply_flag(lsf));
	pfr_drive_model pfr_drive_model_inst (.speed(speed), .decel_request(decel_request),
		.motor_freq(motor_freq), .motor_stopped(motor_stopped), .stopping(stopping));
	task automatic chk(input bit ok, input string msg);
		cmp_count++;
		if (!ok) begin
			bad_count++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask
	// Pulse one fault pin, then await a restart (rs) or a trip
	task automatic hit(input int b, input int len, input bit rs, input logic [15:0] f);
		int n;
		flt[b] <= 1'b1;
		repeat (len) @(posedge mclk);
		flt[b] <= 1'b0;
		n = 0;
		while (!(rs ? restart_start === 1'b1 : tripped === 1'b1) && n < 300) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 300, "no restart or trip");
		if (rs) chk(restart_freq === f, "restart frequency");
		@(posedge mclk);
	endtask
	task automatic clr;
		// Let synchronised fault pins fall first, else a cleared trip re-arms
		repeat (6) @(posedge mclk);
		stop_reset <= 1'b1;
		@(posedge mclk);
		stop_reset <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(tripped === 1'b0 && alarm === 1'b0, "trip not cleared");
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		chk(drive_enable === 1'b1 && tripped === 1'b0, "reset state");
		@(posedge mclk);
		flt[0] <= 1'b1;
		repeat (10) @(posedge mclk);
		chk(plf === 1'b1 && drive_enable === 1'b0, "power loss flag");
		hit(0, 1, 1, 16'h0000);
		chk(plf === 1'b0, "power loss flag stuck");
		mode <= MODE_MATCH;
		speed <= 16'h01f4;
		flt[1] <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(lsf === 1'b1, "low supply flag");
		hit(1, 1, 1, 16'h01f4);
		chk(lsf === 1'b0, "low supply flag stuck");
		speed <= 16'h0032;
		hit(1, 6, 1, 16'h0000);
		for (i = 3; i < 16; i++) hit(i % 2, 6, 1, 16'h0000);
		hit(0, 6, 0, 16'h0000);
		chk(alarm === 1'b1, "17th fault alarm");
		clr();
		mode <= MODE_ZERO;
		for (i = 0; i < 3; i++) hit(2 + i % 2, 6, 1, 16'h0000);
		hit(2, 6, 0, 16'h0000);
		chk(tripped === 1'b1 && alarm === 1'b1, "4th fault trip");
		clr();
		hit(3, 6, 1, 16'h0000);
		mode <= MODE_TRIP;
		hit(0, 6, 0, 16'h0000);
		chk(alarm === 1'b1, "mode 0 alarm");
		clr();
		alm <= ALM_OFF;
		hit(0, 6, 0, 16'h0000);
		chk(alarm === 1'b0, "alarm disabled");
		clr();
		alm <= ALM_OFF_STOPPING;
		hit(0, 6, 0, 16'h0000);
		chk(alarm === 1'b1, "alarm while running");
		clr();
		speed <= 16'h0000;
		hit(0, 6, 0, 16'h0000);
		chk(alarm === 1'b0, "alarm while stopped");
		clr();
		alm <= ALM_ON;
		mode <= MODE_ZERO;
		hit(1, 30, 0, 16'h0000);
		clr();
		mode <= MODE_MATCH_STOP;
		speed <= 16'h01f4;
		hit(0, 6, 1, 16'h01f4);
		repeat (3) @(posedge mclk);
		chk(decel_request === 1'b1, "decel request");
		speed <= 16'h0000;
		repeat (2) @(posedge mclk);
		chk(tripped === 1'b1 && alarm === 1'b1 && decel_request === 1'b0, "decel trip alarm");
		clr();
		mode <= MODE_ZERO;
		cnt <= CNT_UNLIMITED;
		for (i = 0; i < 18; i++) hit(0, 6, 1, 16'h0000);
		chk(tripped === 1'b0, "unlimited mode tripped");
		summarize();
	end
endmodule
`default_nettype wire
